// [core/host_port_defs.svh]
// Constants for the host word-enable strobe port
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH
`define HP_ADDR_W 2
`define HP_DATA_W 32
`define HP_HALF_W 16
`define HP_OFS_CDATA 8'h00
`define HP_OFS_IND_ADDR 8'h04
`define HP_OFS_IND_DATA 8'h08
`define HP_OFS_MISC 8'h0C
`define HP_IDX_CDATA 2'h0
`define HP_IDX_IND_DATA 2'h2
`define HP_BUF_DEPTH 2
`define HP_CTRL_IDLE 5'h1F
`endif

// [core/host_port_pkg.sv]
// Types shared by the host port and the logic that uses it
`include "host_port_defs.svh"
package host_port_pkg;
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic low_half_enable_n;
		logic high_half_enable_n;
	} host_ctrl_t;

	typedef struct packed {
		logic [`HP_ADDR_W-1:0] addr;
		logic [`HP_DATA_W-1:0] data;
		logic low_half;
		logic upper_half_word;
		logic step;
	} write_entry_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_wait = 2'b01,
		st_ack = 2'b11
	} port_state_t;
endpackage

// [core/host_word_enable_strobe_port.sv]
// Asynchronous host port: strobe sync, word enables, pointer steps, write buffer
`timescale 1ns/10ps
`default_nettype none
`include "host_port_defs.svh"
module host_word_enable_strobe_port #(
	parameter int BUF_DEPTH = `HP_BUF_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic low_half_enable_n,
	input wire logic high_half_enable_n,
	input wire logic [`HP_ADDR_W-1:0] adr,
	input wire logic [`HP_DATA_W-1:0] data_in,
	output logic [`HP_DATA_W-1:0] data_out,
	output logic data_oe,
	output logic ack_n,
	input wire logic encode_mode,
	input wire logic fifo_full,
	input wire logic fifo_empty,
	output logic [`HP_ADDR_W-1:0] rd_addr,
	input wire logic [`HP_DATA_W-1:0] rd_data,
	output logic rd_fifo_step,
	output logic rd_ind_step,
	output logic wr_valid,
	output host_port_pkg::write_entry_t wr_entry,
	input wire logic wr_ready
);
	// The buffer control below only knows the full and single-entry cases
	if (BUF_DEPTH != 2) begin
		$error("host port write buffer is built for exactly two entries");
	end

	host_port_pkg::host_ctrl_t ctrl_meta, ctrl_s;
	logic [`HP_ADDR_W-1:0] adr_meta, adr_s;
	logic [`HP_DATA_W-1:0] data_meta, data_s;
	host_port_pkg::port_state_t state;
	logic is_read;
	logic [`HP_ADDR_W-1:0] acc_addr;
	logic acc_low, acc_high;
	host_port_pkg::write_entry_t entry1;
	logic [1:0] count;
	logic strobe_low, stall, push, pop, stepping;
	logic acc_cdata, read_done;
	logic [1:0] next_count;
	host_port_pkg::write_entry_t new_entry;

	function automatic logic is_step_addr(input logic [`HP_ADDR_W-1:0] a);
		is_step_addr = (a == `HP_IDX_CDATA) || (a == `HP_IDX_IND_DATA);
	endfunction

	// Strobes and enables: two flops each, reset to the idle (all high) levels
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_meta <= `HP_CTRL_IDLE;
			ctrl_s <= `HP_CTRL_IDLE;
		end else begin
			ctrl_meta <= {cs_n, wr_n, rd_n, low_half_enable_n, high_half_enable_n};
			ctrl_s <= ctrl_meta;
		end
	end

	// Address and data: two flops as well; the host holds them through a strobe,
	// so they have settled by the time the synchronised strobe is acted on
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			adr_meta <= '0;
			adr_s <= '0;
			data_meta <= '0;
			data_s <= '0;
		end else begin
			adr_meta <= adr;
			adr_s <= adr_meta;
			data_meta <= data_in;
			data_s <= data_meta;
		end
	end

	assign acc_cdata = acc_addr == `HP_IDX_CDATA;
	assign strobe_low = is_read ? !ctrl_s.rd_n : !ctrl_s.wr_n;
	// Only the compressed-data register waits on the FIFO; writes to any register also stall on a full buffer
	assign stall = is_read
		? (acc_cdata && encode_mode && fifo_empty)
		: (count == 2'(BUF_DEPTH))
		|| (acc_cdata && !encode_mode && fifo_full);
	assign stepping = acc_high && is_step_addr(acc_addr);
	assign push = state == host_port_pkg::st_ack && !is_read && !strobe_low;
	assign read_done = state == host_port_pkg::st_ack && is_read && !strobe_low;
	assign pop = wr_valid && wr_ready;
	assign new_entry = '{addr: acc_addr, data: data_s, low_half: acc_low,
		upper_half_word: acc_high, step: stepping};

	// Buffer occupancy after this edge's push and pop
	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + 2'd1;
		else if (pop && !push)
			next_count = count - 2'd1;
	end

	// Access sequencer: a strobe opens an access, the trailing edge closes it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= host_port_pkg::st_idle;
			is_read <= 1'b0;
			acc_addr <= '0;
			acc_low <= 1'b0;
			acc_high <= 1'b0;
			ack_n <= 1'b1;
		end else begin
			unique case (state)
				host_port_pkg::st_idle: begin
					if (!ctrl_s.cs_n && (!ctrl_s.wr_n || !ctrl_s.rd_n)) begin
						state <= host_port_pkg::st_wait;
						is_read <= !ctrl_s.rd_n;
						acc_addr <= adr_s;
						acc_low <= !ctrl_s.low_half_enable_n;
						acc_high <= !ctrl_s.high_half_enable_n;
					end
				end
				host_port_pkg::st_wait: begin
					if (ctrl_s.cs_n || !strobe_low) begin
						state <= host_port_pkg::st_idle;
					end else if (!stall) begin
						state <= host_port_pkg::st_ack;
						ack_n <= 1'b0;
					end
				end
				host_port_pkg::st_ack: begin
					if (!strobe_low || ctrl_s.cs_n) begin
						state <= host_port_pkg::st_idle;
						ack_n <= 1'b1;
					end
				end
				// The one unused code falls back to idle rather than lock the port
				default: begin
					state <= host_port_pkg::st_idle;
					ack_n <= 1'b1;
				end
			endcase
		end
	end

	// Read word: latched in the cycle the acknowledge is given
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_addr <= '0;
			data_out <= '0;
		end else begin
			rd_addr <= adr_s;
			if (state == host_port_pkg::st_wait && is_read && !stall)
				data_out <= rd_data;
		end
	end

	// Bus drive: follows the synchronised select and read strobe, so the pins
	// float about three clocks after chip select rises
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= !ctrl_s.cs_n && !ctrl_s.rd_n && is_read
				&& state != host_port_pkg::st_idle;
		end
	end

	// Read-side pointer steps fire once as an upper-half read ends
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_fifo_step <= 1'b0;
			rd_ind_step <= 1'b0;
		end else begin
			rd_fifo_step <= read_done && acc_high && acc_cdata;
			rd_ind_step <= read_done && acc_high && acc_addr == `HP_IDX_IND_DATA;
		end
	end

	// Two-entry write buffer; a slow consumer holds off ack instead of losing words
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= '0;
			wr_valid <= 1'b0;
		end else begin
			count <= next_count;
			wr_valid <= next_count != 2'd0;
		end
	end

	// Head of the buffer: a new word lands here when the head is free or leaving
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_entry <= '0;
		end else if (push && (count == 2'd0 || (count == 2'd1 && pop))) begin
			wr_entry <= new_entry;
		end else if (pop) begin
			wr_entry <= entry1;
		end
	end

	// Second slot: only filled while the head is still waiting for the consumer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			entry1 <= '0;
		end else if (push && (count == 2'd2 || (count == 2'd1 && !pop))) begin
			entry1 <= new_entry;
		end
	end
endmodule
`default_nettype wire

// [test/hp_checker.sv]
// Assertion checker for the host port
`timescale 1ns/10ps
`default_nettype none
module hp_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic encode_mode,
	input wire logic fifo_full,
	input wire logic fifo_empty,
	input wire logic [1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic [31:0] data_out,
	input wire logic data_oe,
	input wire logic ack_n,
	input wire logic rd_fifo_step,
	input wire logic rd_ind_step,
	input wire logic wr_valid,
	input wire logic wr_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	bus_float_a: assert property (cs_n [*4] |-> !data_oe) else $error("bus driven");
	ack_idle_a: assert property (cs_n [*4] |-> ack_n) else $error("ack unselected");
	read_data_a: assert property ($fell(ack_n) && data_oe |-> data_out == $past(rd_data))
		else $error("read data");
	full_stall_a: assert property ($fell(ack_n) && !data_oe && rd_addr == 2'h0
		&& !encode_mode |-> !$past(fifo_full)) else $error("write not stalled");
	empty_stall_a: assert property ($fell(ack_n) && data_oe && rd_addr == 2'h0
		&& encode_mode |-> !$past(fifo_empty)) else $error("read not stalled");
	fifo_step_a: assert property (rd_fifo_step |-> $rose(ack_n) && rd_addr == 2'h0
		##1 !rd_fifo_step) else $error("fifo step");
	ind_step_a: assert property (rd_ind_step |-> $rose(ack_n) && rd_addr == 2'h2)
		else $error("indirect step");
	push_a: assert property ($rose(wr_valid) |-> $rose(ack_n)) else $error("push");
	buf_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid) else $error("lost");
endmodule
bind host_word_enable_strobe_port hp_checker chk_u (.*);
`default_nettype wire

// [test/core_model.sv]
// Core-side model: read source and write sink
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic clk_sys,
	input wire logic stall,
	input wire logic [1:0] rd_addr,
	output logic [31:0] rd_data,
	output logic wr_ready = 1'b0
);
	// Random back-pressure keeps the write buffer busy
	always @(posedge clk_sys) wr_ready <= !stall && $urandom % 4 != 0;
	assign rd_data = 32'h5a5a_0f0f ^ {30'h0, rd_addr};
endmodule
`default_nettype wire

// [test/host_word_enable_strobe_port_tb.sv]
// Self-checking bench for the host port
`timescale 1ns/10ps
`default_nettype none
module host_word_enable_strobe_port_tb;
	logic clk_sys = 0, rst = 1, cs_n = 1, wr_n = 1, rd_n = 1, encode_mode = 0, stall = 0;
	logic low_half_enable_n = 1, high_half_enable_n = 1, fifo_full = 0, fifo_empty = 0;
	logic wr_ready, data_oe, ack_n, rd_fifo_step, rd_ind_step, wr_valid;
	logic [1:0] adr = 0, rd_addr, a;
	logic [31:0] data_in = 0, data_out, rd_data, d;
	host_port_pkg::write_entry_t wr_entry, q[$];
	int miscompares = 0, compares = 0, n;
	int steps = 0, exp_steps = 0;
	always #4 clk_sys = ~clk_sys;
	host_word_enable_strobe_port dut_u (.*);
	core_model part_u (.*);
	function automatic logic [31:0] exp_word(input logic [1:0] x);
		return 32'h5a5a_0f0f ^ {30'h0, x};
	endfunction
	task chk(input logic [63:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task print_verdict;
		if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task hold(input logic v);
		for (n = 0; n < 40 && ack_n !== v; n++) @(posedge clk_sys);
		chk(ack_n, v);
	endtask
	// lo and hi are pin levels; st expects a stall until the flags clear
	task acc(input logic w, lo, hi, st, input logic [1:0] x, input logic [31:0] v);
		@(posedge clk_sys);
		{cs_n, wr_n, rd_n, low_half_enable_n, high_half_enable_n} <= {1'b0, !w, w, lo, hi};
		adr <= x;
		data_in <= v;
		if (st) begin
			repeat (8) @(posedge clk_sys);
			chk(ack_n, 1);
			{fifo_full, fifo_empty, stall} <= 3'b000;
		end
		hold(0);
		if (w) q.push_back(host_port_pkg::write_entry_t'{x, v, !lo, !hi, !hi && !x[0]});
		else begin
			chk(data_out, exp_word(x));
			chk(data_oe, 1);
			if (!hi && !x[0]) exp_steps += x[1] ? 256 : 1;
		end
		{wr_n, rd_n} <= 2'b11;
		hold(1);
		cs_n <= 1;
	endtask
	always @(posedge clk_sys) if (wr_valid && wr_ready) chk(wr_entry, q.pop_front());
	always @(posedge clk_sys) steps += (rd_fifo_step === 1'b1) + 256 * (rd_ind_step === 1'b1);
	initial begin
		void'($urandom(7445));
		repeat (4) @(posedge clk_sys);
		rst <= 0;
		for (int i = 0; i < 30; i++) begin
			a = $urandom;
			d = $urandom;
			if (i % 2) acc(i % 3 == 0, 0, 0, 0, a, d);
			else begin
				acc(i % 3 == 0, 0, 1, 0, a, d);
				acc(i % 3 == 0, 1, 0, 0, a, d);
			end
		end
		stall <= 1;
		for (int j = 0; j < 3; j++) acc(1, 0, 0, j == 2, 2'h1, d);
		fifo_full <= 1;
		acc(1, 0, 0, 1, 2'h0, d);
		{encode_mode, fifo_empty} <= 2'b11;
		acc(0, 0, 0, 1, 2'h0, d);
		fifo_full <= 1;
		acc(1, 0, 0, 0, 2'h0, d);
		wr_n <= 0;
		repeat (8) @(posedge clk_sys);
		chk(ack_n, 1);
		chk(data_oe, 0);
		wr_n <= 1;
		repeat (9) @(posedge clk_sys);
		chk(q.size(), 0);
		chk(steps, exp_steps);
		print_verdict();
	end
	// Far beyond the few hundred cycles the sequence needs
	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
